// ---- pkg/pct_pkg.sv ----
// Constants, field layout and types of the pulse capture timer.
// Assumes a 32-bit AHB-Lite register bus; each register is one aligned word.
package pct_pkg;
  // ****************************************
  // Register indices (byte address = 4 * index)
  // ****************************************
  localparam logic [29:0] IDX_MODE = 30'h0A0;
  localparam logic [29:0] IDX_CNT_LO = 30'h0A1;
  localparam logic [29:0] IDX_CNT_HI = 30'h0A2;
  localparam logic [29:0] IDX_EVT_LO = 30'h0A3;
  localparam logic [29:0] IDX_EVT_HI = 30'h0A4;
  localparam logic [29:0] IDX_EVT_CTL = 30'h0A5;
  localparam logic [29:0] IDX_STAT = 30'h0A6;
  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int RUN_BIT = 7;
  localparam int PSEL_HI = 6;
  localparam int PSEL_LO = 4;
  localparam int SRC_BIT = 3;
  localparam int GO_BIT = 2;
  localparam int CAPM_HI = 1;
  localparam int CAPM_LO = 0;
  localparam int EVT_EN_BIT = 7;
  localparam int FLAG_BIT = 0;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [6:0] PRESC_MASK = 7'h7F;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [11:0] EVT_MAX = 12'hFFF;
  // ****************************************
  // Capture modes and states
  // ****************************************
  localparam logic [1:0] CAP_OFF = 2'h0;
  localparam logic [1:0] CAP_HIGH = 2'h1;
  localparam logic [1:0] CAP_LOW = 2'h2;
  localparam logic [1:0] CAP_CYCLE = 2'h3;
  typedef enum logic [2:0] {
    CAP_IDLE = 3'b001,
    CAP_WAIT = 3'b010,
    CAP_RUN = 3'b100
  } pct_cap_e;
endpackage : pct_pkg

// ---- logic/pct_timer.sv ----
// 16-bit pulse capture timer with prescaler, event counter and AHB-Lite slave.
// Assumes hclk is the instruction clock and inputs are synchronous to it.
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pct_timer
  import pct_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Capture sources
  input wire logic cap_pin,
  input wire logic cmp_out,
  // System
  input wire logic green_mode,
  output logic wake_req,
  output logic overflow_flag
);
  // ****************************************
  // Declarations
  // ****************************************
  logic [7:0] mode_reg;
  logic [15:0] cnt_reg;
  logic [7:0] cnt_hi_buf_reg;
  logic [7:0] cnt_rd_hi_reg;
  logic [11:0] evt_reg;
  logic [3:0] evt_hi_buf_reg;
  logic [3:0] evt_rd_hi_reg;
  logic evt_en_reg;
  logic flag_reg;
  logic wake_reg;
  logic [6:0] presc_reg;
  logic [1:0] in_s1_reg;
  logic [1:0] in_s2_reg;
  logic [1:0] in_prev_reg;
  pct_cap_e cap_reg;
  logic dp_wr_reg;
  logic dp_rd_reg;
  logic [29:0] dp_idx_reg;
  logic ready_reg;
  logic [31:0] rdata_reg;
  logic [7:0] rd_val;

  logic run;
  logic capture_source_sel;
  logic [2:0] psel;
  logic [1:0] capm;
  logic cap_on;
  logic acc;
  logic wr_mode;
  logic wr_clo;
  logic wr_chi;
  logic wr_elo;
  logic wr_ehi;
  logic wr_ectl;
  logic wr_stat;
  logic rd_now;
  logic [6:0] pmask;
  logic tick;
  logic rise;
  logic fall;
  logic start_edge;
  logic stop_edge;
  logic go_req;
  logic evt_ovf;
  logic cap_done;
  logic count_en;
  logic ovf_evt;
  logic flag_clr;

  // ****************************************
  // Decode
  // ****************************************
  assign run = mode_reg[RUN_BIT];
  assign psel = mode_reg[PSEL_HI:PSEL_LO];
  assign capm = mode_reg[CAPM_HI:CAPM_LO];
  assign cap_on = (capm != CAP_OFF);
  assign capture_source_sel = mode_reg[SRC_BIT];
  assign acc = hsel & htrans[1] & hready;
  assign wr_mode = dp_wr_reg & (dp_idx_reg == IDX_MODE);
  assign wr_clo = dp_wr_reg & (dp_idx_reg == IDX_CNT_LO);
  assign wr_chi = dp_wr_reg & (dp_idx_reg == IDX_CNT_HI);
  assign wr_elo = dp_wr_reg & (dp_idx_reg == IDX_EVT_LO);
  assign wr_ehi = dp_wr_reg & (dp_idx_reg == IDX_EVT_HI);
  assign wr_ectl = dp_wr_reg & (dp_idx_reg == IDX_EVT_CTL);
  assign wr_stat = dp_wr_reg & (dp_idx_reg == IDX_STAT);
  assign rd_now = dp_rd_reg & ~ready_reg;

  // ****************************************
  // Prescaler and edges
  // ****************************************
  assign pmask = PRESC_MASK >> psel;
  assign tick = ((presc_reg & pmask) == pmask);
  // Both lines are synchronised apart, so a source change never looks like an edge
  assign rise = in_s2_reg[capture_source_sel] & ~in_prev_reg[capture_source_sel];
  assign fall = ~in_s2_reg[capture_source_sel] & in_prev_reg[capture_source_sel];
  assign start_edge = (capm == CAP_LOW) ? fall : rise;
  assign stop_edge = (capm == CAP_HIGH) ? fall : rise;
  assign go_req = wr_mode & hwdata[GO_BIT]
    & (hwdata[CAPM_HI:CAPM_LO] != CAP_OFF);
  assign evt_ovf = evt_en_reg & (cap_reg == CAP_RUN) & rise
    & (evt_reg == EVT_MAX);
  assign cap_done = run & cap_on & (cap_reg == CAP_RUN)
    & (evt_en_reg ? evt_ovf : stop_edge);
  assign count_en = run & tick & ~cap_done
    & (~cap_on | (cap_reg == CAP_RUN));
  assign ovf_evt = count_en & (cnt_reg == CNT_MAX);
  assign flag_clr = wr_stat & hwdata[FLAG_BIT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      presc_reg <= '0;
    end else begin
      presc_reg <= presc_reg + 7'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_s1_reg <= 2'b00;
      in_s2_reg <= 2'b00;
      in_prev_reg <= 2'b00;
    end else begin
      in_s1_reg <= {cmp_out, cap_pin};
      in_s2_reg <= in_s1_reg;
      in_prev_reg <= in_s2_reg;
    end
  end

  // ****************************************
  // Mode register and capture sequencer
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_reg <= BYTE_RST;
    end else if (wr_mode) begin
      mode_reg <= hwdata[7:0];
    end else if (cap_done) begin
      mode_reg[GO_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_reg <= CAP_IDLE;
    end else if (go_req) begin
      cap_reg <= CAP_WAIT;
    end else if (wr_mode | ~cap_on) begin
      cap_reg <= (wr_mode & hwdata[GO_BIT] & cap_on) ? cap_reg : CAP_IDLE;
    end else begin
      unique case (cap_reg)
        CAP_IDLE: begin
          cap_reg <= CAP_IDLE;
        end
        CAP_WAIT: begin
          if (run & start_edge) begin
            cap_reg <= CAP_RUN;
          end
        end
        CAP_RUN: begin
          if (cap_done) begin
            cap_reg <= CAP_IDLE;
          end
        end
        default: begin
          cap_reg <= CAP_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Counter, event counter and flag
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= '0;
    end else if (wr_clo) begin
      cnt_reg <= {cnt_hi_buf_reg, hwdata[7:0]};
    end else if (go_req) begin
      cnt_reg <= '0;
    end else if (count_en) begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_hi_buf_reg <= BYTE_RST;
      evt_hi_buf_reg <= '0;
    end else begin
      if (wr_chi) begin
        cnt_hi_buf_reg <= hwdata[7:0];
      end
      if (wr_ehi) begin
        evt_hi_buf_reg <= hwdata[3:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_reg <= '0;
    end else if (wr_elo) begin
      evt_reg <= {evt_hi_buf_reg, hwdata[7:0]};
    end else if (evt_en_reg & cap_on & (cap_reg == CAP_RUN) & rise) begin
      evt_reg <= evt_reg + 12'h001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_en_reg <= 1'b0;
    end else if (wr_ectl) begin
      evt_en_reg <= hwdata[EVT_EN_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= ovf_evt | cap_done | (flag_reg & ~flag_clr);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= green_mode & ovf_evt;
    end
  end

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_reg <= 1'b0;
      dp_rd_reg <= 1'b0;
      dp_idx_reg <= '0;
    end else if (acc) begin
      dp_wr_reg <= hwrite;
      dp_rd_reg <= ~hwrite;
      dp_idx_reg <= haddr[31:2];
    end else if (hready) begin
      dp_wr_reg <= 1'b0;
      dp_rd_reg <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ready_reg <= 1'b1;
    end else begin
      ready_reg <= ~(acc & ~hwrite);
    end
  end

  always_comb begin
    rd_val = 8'h00;
    unique case (dp_idx_reg)
      IDX_MODE: rd_val = mode_reg;
      IDX_CNT_LO: rd_val = cnt_reg[7:0];
      IDX_CNT_HI: rd_val = cnt_rd_hi_reg;
      IDX_EVT_LO: rd_val = evt_reg[7:0];
      IDX_EVT_HI: rd_val = {4'h0, evt_rd_hi_reg};
      IDX_EVT_CTL: rd_val = {evt_en_reg, 7'h00};
      IDX_STAT: rd_val = {7'h00, flag_reg};
      default: rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_reg <= '0;
    end else if (rd_now) begin
      rdata_reg <= {24'h000000, rd_val};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_rd_hi_reg <= BYTE_RST;
      evt_rd_hi_reg <= '0;
    end else if (rd_now) begin
      if (dp_idx_reg == IDX_CNT_LO) begin
        cnt_rd_hi_reg <= cnt_reg[15:8];
      end
      if (dp_idx_reg == IDX_EVT_LO) begin
        evt_rd_hi_reg <= evt_reg[11:8];
      end
    end
  end

  assign hreadyout = ready_reg;
  assign hresp = 1'b0;
  assign hrdata = rdata_reg;
  assign wake_req = wake_reg;
  assign overflow_flag = flag_reg;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  ovf_flag_set_a: assert property (ovf_evt |=> flag_reg)
    else $error("overflow did not set flag");
  flag_hold_a: assert property (flag_reg & ~flag_clr |=> flag_reg)
    else $error("flag dropped without clear");
  stop_hold_a: assert property (~run & ~wr_clo & ~go_req |=> $stable(cnt_reg))
    else $error("counter moved while stopped");
  full_rate_a: assert property (run & ~cap_on & (psel == 3'h7) & ~wr_clo & ~go_req
    |=> cnt_reg == $past(cnt_reg) + 16'h0001)
    else $error("divide by one did not step");
  slow_rate_a: assert property (run & (psel == 3'h0) & tick & ~wr_clo & ~go_req
    |=> (~tick)[*8])
    else $error("divide by 128 ticked too soon");
  cap_clear_a: assert property (go_req & ~wr_clo |=> cnt_reg == 16'h0000)
    else $error("start did not clear counter");
  wait_start_a: assert property (cap_reg == CAP_WAIT & run & cap_on & start_edge
    & ~wr_mode |=> cap_reg == CAP_RUN)
    else $error("first edge did not start capture");
  cap_done_a: assert property (cap_done & ~wr_mode
    |=> ~mode_reg[GO_BIT] & flag_reg & cap_reg == CAP_IDLE)
    else $error("capture end incomplete");
  low_write_a: assert property (wr_clo
    |=> cnt_reg == {$past(cnt_hi_buf_reg), $past(hwdata[7:0])})
    else $error("low byte write did not load counter");
  read_latch_a: assert property (rd_now & dp_idx_reg == IDX_CNT_LO
    |=> cnt_rd_hi_reg == $past(cnt_reg[15:8]))
    else $error("low read did not latch high byte");
  evt_step_a: assert property (evt_en_reg & cap_on & cap_reg == CAP_RUN & rise & ~wr_elo
    |=> evt_reg == $past(evt_reg) + 12'h001)
    else $error("event counter missed edge");
  wake_a: assert property (green_mode & ovf_evt |=> wake_req)
    else $error("no wake on green overflow");
  mode_off_a: assert property (wr_mode & hwdata[GO_BIT] & hwdata[1:0] == CAP_OFF & ~wr_clo
    & ~count_en |=> $stable(cnt_reg))
    else $error("start with capture off touched counter");

  cap_done_c: cover property (cap_done & ~evt_en_reg);
  evt_done_c: cover property (cap_done & evt_en_reg);
  ovf_c: cover property (ovf_evt & ~cap_on);
  read_c: cover property (rd_now & dp_idx_reg == IDX_CNT_LO ##3 rd_now);
endmodule : pct_timer
`default_nettype wire

// ---- bench/pct_sig_src.sv ----
// Model of the capture sources: external pin and comparator output.
// Assumes one free-running hclk; both lines are plain levels.
`timescale 1ns/1ps
`default_nettype none
module pct_sig_src (
  // Clock
  input wire logic hclk,
  // Capture sources
  output logic cap_pin,
  output logic cmp_out
);
  // ****************************************
  // Waveforms: period 50, pin high 21, comparator high 30
  // ****************************************
  logic [5:0] ph = 6'h00;
  initial begin
    cap_pin = 1'b0;
    cmp_out = 1'b1;
  end
  always @(posedge hclk) begin
    ph <= (ph == 6'h31) ? 6'h00 : ph + 6'h01;
    cap_pin <= (ph >= 6'h1D);
    cmp_out <= (ph < 6'h1E);
  end
endmodule : pct_sig_src
`default_nettype wire

// ---- bench/pct_timer_tb.sv ----
// Self-checking bench of the pulse capture timer over AHB-Lite.
// Assumes one slave whose hreadyout is the bus hready.
`timescale 1ns/1ps
`default_nettype none
module pct_timer_tb;
  import pct_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic green_mode = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  wire logic hreadyout, hresp, wake_req, overflow_flag, cap_pin, cmp_out;
  wire logic [31:0] hrdata;
  int err_count = 0;
  int cmp_count = 0;
  logic [31:0] rd;
  logic [31:0] keep;
  pct_timer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cap_pin(cap_pin),
    .cmp_out(cmp_out), .green_mode(green_mode), .wake_req(wake_req),
    .overflow_flag(overflow_flag));
  pct_sig_src src (.hclk(hclk), .cap_pin(cap_pin), .cmp_out(cmp_out));
  initial begin
    forever #2.5 hclk = ~hclk;
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic give_verdict();
    if (err_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  task automatic check(input string nm, input logic [31:0] seen, exp, input int tol = 0);
    cmp_count++;
    if (tol == 0 ? seen !== exp : ($isunknown(seen) || seen + tol < exp || seen > exp + tol)) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic wait_sig(input int sel, input int lim);
    int n;
    logic v;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
      v = (sel == 0) ? hreadyout : (sel == 1) ? overflow_flag : wake_req;
    end while (v !== 1'b1 && n < lim);
    if (v !== 1'b1) begin
      err_count++;
      give_verdict();
    end
  endtask : wait_sig
  task automatic bus(input logic wr, input logic [29:0] idx, input logic [7:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {idx, 2'b00};
    hwrite <= wr;
    wait_sig(0, 20);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    wait_sig(0, 20);
    rd = hrdata;
    check("hresp", {31'h0, hresp}, 32'h0);
  endtask : bus
  task automatic wr(input logic [29:0] idx, input logic [7:0] wd);
    bus(1'b1, idx, wd);
  endtask : wr
  task automatic rdck(input logic [29:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 8'h00);
    check("register", rd, exp);
  endtask : rdck
  task automatic rdcnt(input logic [31:0] exp, input int tol);
    bus(1'b0, IDX_CNT_LO, 8'h00);
    keep = rd;
    bus(1'b0, IDX_CNT_HI, 8'h00);
    check("count", {rd[23:0], keep[7:0]}, exp, tol);
  endtask : rdcnt
  task automatic cap(input logic src_sel, input logic [1:0] mode, input logic [31:0] exp);
    logic [7:0] m;
    m = {1'b1, 3'h7, src_sel, 1'b0, mode};
    wr(IDX_STAT, 8'h01);
    wr(IDX_CNT_HI, 8'h55);
    wr(IDX_CNT_LO, 8'h55);
    wr(IDX_MODE, m);
    wr(IDX_MODE, m | 8'h04);
    wait_sig(1, 600);
    rdck(IDX_MODE, {24'h0, m});
    rdcnt(exp, 2);
    wr(IDX_MODE, 8'h00);
  endtask : cap
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 8; i++) rdck(30'(IDX_MODE + i), 32'h0);
    wr(30'h0A8, 8'hFF);
    rdck(30'h0A8, 32'h0);
    wr(IDX_CNT_HI, 8'h12);
    rdcnt(32'h0, 0);
    wr(IDX_CNT_LO, 8'h34);
    rdcnt(32'h1234, 0);
    wr(IDX_CNT_HI, 8'h00);
    wr(IDX_CNT_LO, 8'hF0);
    wr(IDX_MODE, 8'hF0);
    bus(1'b0, IDX_CNT_LO, 8'h00);
    repeat (300) @(posedge hclk);
    rdck(IDX_CNT_HI, 32'h0);
    wr(IDX_MODE, 8'h00);
    for (int c = 0; c < 8; c++) begin
      wr(IDX_CNT_HI, 8'h00);
      wr(IDX_CNT_LO, 8'h00);
      wr(IDX_MODE, {1'b1, 3'(c), 4'h0});
      repeat (256) @(posedge hclk);
      wr(IDX_MODE, {1'b0, 3'(c), 4'h0});
      rdcnt(32'(2 << c), (c > 4) ? 3 : 1);
    end
    wr(IDX_STAT, 8'h01);
    wr(IDX_CNT_HI, 8'hFF);
    wr(IDX_CNT_LO, 8'h00);
    green_mode <= 1'b1;
    wr(IDX_MODE, 8'hF0);
    rdck(IDX_STAT, 32'h0);
    wait_sig(2, 300);
    check("flag", {31'h0, overflow_flag}, 32'h1);
    green_mode <= 1'b0;
    wr(IDX_MODE, 8'h70);
    bus(1'b0, IDX_CNT_LO, 8'h00);
    keep = rd;
    repeat (40) @(posedge hclk);
    rdck(IDX_CNT_LO, keep);
    rdck(IDX_STAT, 32'h1);
    wr(IDX_STAT, 8'h01);
    rdck(IDX_STAT, 32'h0);
    wr(IDX_CNT_HI, 8'h77);
    wr(IDX_CNT_LO, 8'h77);
    wr(IDX_MODE, 8'h04);
    rdcnt(32'h7777, 0);
    for (int s = 0; s < 2; s++)
      for (int m = 1; m < 4; m++)
        cap(1'(s), 2'(m), (m == 3) ? 50 : (((m == 1) ^ (s == 1)) ? 20 : 30));
    wr(IDX_EVT_HI, 8'hFF);
    wr(IDX_EVT_LO, 8'hFC);
    rdck(IDX_EVT_LO, 32'hFC);
    rdck(IDX_EVT_HI, 32'h0F);
    wr(IDX_EVT_CTL, 8'h80);
    rdck(IDX_EVT_CTL, 32'h80);
    cap(1'b0, 2'h3, 32'd200);
    give_verdict();
  end
endmodule : pct_timer_tb
`default_nettype wire
